//--- pkg/spi_eeprom_map.svh
// constants and link contract for the serial eeprom device and its spi master
`ifndef SPI_EEPROM_MAP_SVH
`define SPI_EEPROM_MAP_SVH
// Contract
// - read: opcode, 16-bit address, then data out
// - input ignored after read address received
// - read auto-increments, wraps to address zero
// - master raises select after eighth bit
// - write without latch set is ignored
// - protected addresses are never programmed
// - busy: only status read is executed
// - write: opcode, address, data; program on deselect
// - master deselects in clock low after bit
// - status bit 0 shows programming busy
// - page write increments low five bits only
// - over 32 bytes wraps within page
// - programming end clears write latch
// - ignored write waits for new select
// - only low 10 to 13 address bits decoded
// - opcodes 0000X011/0000X010, msb first framing
// - pin low with enable bit: hard protection
// - protect bits: none, quarter, half, all

// opcodes: upper nibble zero, bit 3 don't care, low three bits decoded
`define SET_WRITE_LATCH_CMD   3'h6
`define CLEAR_WRITE_LATCH_CMD 3'h4
`define STATUS_READ_CMD       3'h5
`define STATUS_WRITE_CMD      3'h1
`define ARRAY_READ_CMD        3'h3
`define ARRAY_WRITE_CMD       3'h2

// status byte layout
`define ST_BUSY_BIT           0
`define ST_LATCH_BIT          1
`define ST_BLOCK_LO_BIT       2
`define ST_BLOCK_HI_BIT       3
`define ST_PROTECT_PIN_BIT    7
`define ST_BUSY_VALUE         8'hFF

`define PAGE_BITS             5
`define ADDR_BITS_DEFAULT     13
`define ADDR_BITS_MIN         10
`define ADDR_BITS_MAX         13

// timing
`define SYS_CLK_NS            20
`define WRITE_CYCLE_NS        100000
`define WRITE_CYCLE_CYCLES    (`WRITE_CYCLE_NS / `SYS_CLK_NS)
`define SCK_HALF_DEFAULT      4
`define SCK_HALF_MIN          3

// master register port
`define HOST_TX_REG           2'h0
`define HOST_RX_REG           2'h1
`define HOST_STAT_REG         2'h2
`define HOST_PIN_REG          2'h3
`define HOST_END_FRAME_BIT    8
`define HOST_BUSY_BIT         0
`define HOST_OPEN_BIT         1
`define HOST_WP_RESET         1'h1
`endif

//--- pkg/spi_eeprom_pkg.sv
// types shared by the serial eeprom device and the spi master
`default_nettype none
package spi_eeprom_pkg;
   typedef enum logic [2:0] {
      ls_cmd, ls_addr_hi, ls_addr_lo, ls_read, ls_wdata, ls_stat, ls_status_write_cmd, ls_ignore
   } link_state_type;
   typedef enum logic [2:0] {
      fk_none, fk_set_latch, fk_clear_latch, fk_status_write, fk_array_write
   } frame_kind_type;
   typedef enum logic [1:0] {
      hs_idle, hs_shift, hs_finish
   } host_state_type;
endpackage
`default_nettype wire

//--- pkg/spi_link_if.sv
// spi link between the eeprom device and its master
`timescale 1ns/1ps
`default_nettype none
interface spi_link_if;
   logic sck;
   logic cs_n;
   logic si;
   logic so;
   logic so_oe;
   logic wp_n;
   // released output line reads low in this model
   logic so_line;
   assign so_line = so & so_oe;
   modport device_end (input sck, input cs_n, input si, input wp_n, output so, output so_oe);
   modport master_end (output sck, output cs_n, output si, output wp_n, input so_line);
endinterface
`default_nettype wire

//--- logic/eeprom_device.sv
// serial eeprom device: command sequencer, page buffer, array and write cycle timer
`timescale 1ns/1ps
`default_nettype none
`include "spi_eeprom_map.svh"
module eeprom_device
   import spi_eeprom_pkg::*;
#(
   parameter int ADDR_BITS    = `ADDR_BITS_DEFAULT,
   parameter int WRITE_CYCLES = `WRITE_CYCLE_CYCLES
) (
   // system clock and reset
   input  wire logic sys_clk,
   input  wire logic srst,
   // link pins
   spi_link_if.device_end link,
   // user side
   output logic       busy
);
   localparam int NPAGE = 1 << `PAGE_BITS;

   if (ADDR_BITS < `ADDR_BITS_MIN || ADDR_BITS > `ADDR_BITS_MAX) begin : g_bad_addr
      $error("eeprom_device: ADDR_BITS must lie in 10..13");
   end
   if (WRITE_CYCLES < 1) begin : g_bad_cyc
      $error("eeprom_device: WRITE_CYCLES must be at least 1");
   end

   ////////////////////////////////////////////////////////////////////////////
   // shared state

   logic [7:0]              mem [2**ADDR_BITS];
   logic [7:0]              page_buf [NPAGE];
   logic [NPAGE-1:0]        page_valid;
   logic [ADDR_BITS-1:`PAGE_BITS] page_hi;
   frame_kind_type          kind;
   logic                    frame_tog;
   logic                    partial;
   logic [7:0]              status_write_cmd_val;
   logic                    wel;
   logic [1:0]              block_prot;
   logic                    protect_pin_enable_bit;
   logic [7:0]              status_byte;

   ////////////////////////////////////////////////////////////////////////////
   // link domain

   link_state_type          state;
   logic [2:0]              bit_cnt;
   logic [6:0]              shift;
   logic [15:0]             addr;
   logic [1:0]              busy_sync;
   logic [7:0]              stat_meta;
   logic [7:0]              stat_sync;

   wire       [7:0] next_byte = {shift, link.si};
   // full start address as it completes; only the decoded page bits are kept
   wire      [15:0] full_addr = {addr[15:8], next_byte};
   wire             byte_done = (bit_cnt == 3'h7);
   wire             first_bit = (state == ls_cmd) && (bit_cnt == 3'h0);
   wire             op_ok     = (next_byte[7:4] == 4'h0);
   wire       [2:0] op        = next_byte[2:0];
   wire             busy_s    = busy_sync[1];
   wire             allowed   = !busy_s || (op == `STATUS_READ_CMD);
   wire [ADDR_BITS-1:0] raddr    = addr[ADDR_BITS-1:0];
   wire [ADDR_BITS-1:0] next_raddr = raddr + 1'b1;
   wire [`PAGE_BITS-1:0] widx    = addr[`PAGE_BITS-1:0];
   wire [`PAGE_BITS-1:0] next_widx = widx + 1'b1;
   wire       [7:0] out_byte  = (state == ls_stat) ? stat_sync : mem[raddr];

   // bit counter and sequencer reset on every deselect, so a new frame needs a fresh falling edge of select
   always_ff @(posedge link.sck or posedge link.cs_n) begin
      if (link.cs_n) begin
         state   <= ls_cmd;
         bit_cnt <= 3'h0;
         shift   <= 7'h00;
         addr    <= 16'h0000;
      end else begin
         bit_cnt <= bit_cnt + 3'h1;
         shift   <= next_byte[6:0];
         if (byte_done) begin
            case (state)
               ls_cmd: begin
                  if (!op_ok || !allowed) begin
                     state <= ls_ignore;
                  end else begin
                     case (op)
                        `ARRAY_READ_CMD:   state <= ls_addr_hi;
                        `ARRAY_WRITE_CMD:  state <= ls_addr_hi;
                        `STATUS_READ_CMD:  state <= ls_stat;
                        `STATUS_WRITE_CMD: state <= ls_status_write_cmd;
                        default:           state <= ls_ignore;
                     endcase
                  end
               end
               ls_addr_hi: begin
                  addr[15:8] <= next_byte;
                  state      <= ls_addr_lo;
               end
               ls_addr_lo: begin
                  addr[7:0] <= next_byte;
                  state     <= (kind == fk_array_write) ? ls_wdata : ls_read;
               end
               ls_read: addr[ADDR_BITS-1:0] <= next_raddr;
               ls_wdata: addr[`PAGE_BITS-1:0] <= next_widx;
               ls_status_write_cmd: state <= ls_ignore;
               ls_stat: state <= ls_stat;
               ls_ignore: state <= ls_ignore;
               default: state <= ls_ignore;
            endcase
         end
      end
   end

   // frame results stay put after deselect; the system side reads them once select is high
   always_ff @(posedge link.sck or posedge srst) begin
      if (srst) begin
         kind       <= fk_none;
         frame_tog  <= 1'b0;
         page_valid <= '0;
         partial    <= 1'b0;
         status_write_cmd_val   <= 8'h00;
         page_hi    <= '0;
      end else begin
         if (first_bit) begin
            frame_tog  <= ~frame_tog;
            kind       <= fk_none;
            page_valid <= '0;
            partial    <= 1'b1;
         end
         if (state == ls_cmd && byte_done && op_ok && allowed) begin
            case (op)
               `SET_WRITE_LATCH_CMD:   kind <= fk_set_latch;
               `CLEAR_WRITE_LATCH_CMD: kind <= fk_clear_latch;
               `STATUS_WRITE_CMD:      kind <= fk_status_write;
               `ARRAY_WRITE_CMD:       kind <= fk_array_write;
               default:                kind <= fk_none;
            endcase
         end
         if (state == ls_addr_lo && byte_done) begin
            page_hi <= full_addr[ADDR_BITS-1:`PAGE_BITS];
         end
         if (state == ls_wdata || state == ls_status_write_cmd) begin
            partial <= !byte_done;
         end
         if (state == ls_wdata && byte_done) begin
            page_valid[widx] <= 1'b1;
         end
         if (state == ls_status_write_cmd && byte_done) begin
            status_write_cmd_val <= next_byte;
         end
      end
   end

   always_ff @(posedge link.sck) begin
      if (state == ls_wdata && byte_done) begin
         page_buf[widx] <= next_byte;
      end
   end

   always_ff @(posedge link.sck or posedge srst) begin
      if (srst) begin
         busy_sync <= 2'b00;
         stat_meta <= 8'h00;
         stat_sync <= 8'h00;
      end else begin
         busy_sync <= {busy_sync[0], busy};
         stat_meta <= status_byte;
         stat_sync <= stat_meta;
      end
   end

   always_ff @(negedge link.sck or posedge link.cs_n) begin
      if (link.cs_n) begin
         link.so_oe <= 1'b0;
         link.so    <= 1'b0;
      end else begin
         link.so_oe <= (state == ls_read) || (state == ls_stat);
         link.so    <= out_byte[~bit_cnt];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // system domain

   logic [2:0]  cs_sync;
   logic [1:0]  wp_sync;
   logic [1:0]  tog_sync;
   logic        tog_done;
   logic [$clog2(WRITE_CYCLES+1)-1:0] cyc_cnt;

   wire         cs_rise   = cs_sync[1] && !cs_sync[2];
   wire         commit    = cs_rise && (tog_sync[1] != tog_done);
   wire         hw_prot   = protect_pin_enable_bit && !wp_sync[1];
   wire         frame_ok  = commit && wel && !partial && !busy;
   wire         do_status_write_cmd   = frame_ok && (kind == fk_status_write) && !hw_prot;
   wire         do_write  = frame_ok && (kind == fk_array_write) && (page_valid != '0);
   wire         cyc_end   = busy && (cyc_cnt == ($clog2(WRITE_CYCLES+1))'(WRITE_CYCLES - 1));

   assign status_byte = busy ? `ST_BUSY_VALUE :
                        {protect_pin_enable_bit, 3'h0, block_prot, wel, 1'b0};

   function automatic logic is_protected(input logic [ADDR_BITS-1:0] a, input logic [1:0] bp);
      case (bp)
         2'b01:   is_protected = (a[ADDR_BITS-1 -: 2] == 2'b11);
         2'b10:   is_protected = a[ADDR_BITS-1];
         2'b11:   is_protected = 1'b1;
         default: is_protected = 1'b0;
      endcase
   endfunction

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cs_sync  <= 3'h7;
         wp_sync  <= 2'b11;
         tog_sync <= 2'b00;
         tog_done <= 1'b0;
      end else begin
         cs_sync  <= {cs_sync[1:0], link.cs_n};
         wp_sync  <= {wp_sync[0], link.wp_n};
         tog_sync <= {tog_sync[0], frame_tog};
         if (cs_rise) begin
            tog_done <= tog_sync[1];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         busy                   <= 1'b0;
         cyc_cnt                <= '0;
         wel                    <= 1'b0;
         block_prot             <= 2'b00;
         protect_pin_enable_bit <= 1'b0;
      end else begin
         if (do_write || do_status_write_cmd) begin
            busy    <= 1'b1;
            cyc_cnt <= '0;
         end else if (cyc_end) begin
            busy <= 1'b0;
            wel  <= 1'b0;
         end else if (busy) begin
            cyc_cnt <= cyc_cnt + 1'b1;
         end
         if (commit && !busy && kind == fk_set_latch) begin
            wel <= 1'b1;
         end
         if (commit && !busy && kind == fk_clear_latch) begin
            wel <= 1'b0;
         end
         if (do_status_write_cmd) begin
            block_prot             <= {status_write_cmd_val[`ST_BLOCK_HI_BIT], status_write_cmd_val[`ST_BLOCK_LO_BIT]};
            protect_pin_enable_bit <= status_write_cmd_val[`ST_PROTECT_PIN_BIT];
         end
      end
   end

   // every received, unprotected page byte lands in one cycle at the start of the write cycle
   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < NPAGE; i++) begin
         if (do_write && page_valid[i] && !is_protected({page_hi, `PAGE_BITS'(i)}, block_prot)) begin
            mem[{page_hi, `PAGE_BITS'(i)}] <= page_buf[i];
         end
      end
   end
endmodule
`default_nettype wire

//--- logic/spi_master_ctrl.sv
// spi master: byte-at-a-time frames ordered through a small register port
`timescale 1ns/1ps
`default_nettype none
`include "spi_eeprom_map.svh"
module spi_master_ctrl
   import spi_eeprom_pkg::*;
#(
   parameter int SCK_HALF = `SCK_HALF_DEFAULT
) (
   // system clock and reset
   input  wire logic        sys_clk,
   input  wire logic        srst,
   // register port
   input  wire logic [1:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   // link pins
   spi_link_if.master_end   link
);
   if (SCK_HALF < `SCK_HALF_MIN) begin : g_bad_half
      $error("spi_master_ctrl: SCK_HALF must be at least 3");
   end

   host_state_type state;
   logic [$clog2(SCK_HALF+1)-1:0] div;
   logic [2:0]  bit_idx;
   logic [7:0]  tx;
   logic [7:0]  rx;
   logic        end_frame;
   logic [1:0]  miso_sync;

   wire         host_busy = (state != hs_idle);
   wire         start     = reg_wr && (reg_addr == `HOST_TX_REG) && !host_busy;
   wire         half_done = (div == ($clog2(SCK_HALF+1))'(SCK_HALF - 1));
   wire  [15:0] rd_mux    = (reg_addr == `HOST_RX_REG)   ? {8'h00, rx} :
                            (reg_addr == `HOST_STAT_REG) ? {14'h0000, !link.cs_n, host_busy} :
                            (reg_addr == `HOST_PIN_REG)  ? {15'h0000, link.wp_n} : 16'h0000;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         miso_sync <= 2'b00;
         reg_rdata <= 16'h0000;
         link.wp_n <= `HOST_WP_RESET;
      end else begin
         miso_sync <= {miso_sync[0], link.so_line};
         reg_rdata <= reg_rd ? rd_mux : 16'h0000;
         if (reg_wr && reg_addr == `HOST_PIN_REG) begin
            link.wp_n <= reg_wdata[0];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state     <= hs_idle;
         div       <= '0;
         bit_idx   <= 3'h7;
         tx        <= 8'h00;
         rx        <= 8'h00;
         end_frame <= 1'b0;
         link.sck  <= 1'b0;
         link.cs_n <= 1'b1;
         link.si   <= 1'b0;
      end else begin
         div <= half_done ? '0 : div + 1'b1;
         case (state)
            hs_idle: begin
               div <= '0;
               if (start) begin
                  tx        <= reg_wdata[7:0];
                  end_frame <= reg_wdata[`HOST_END_FRAME_BIT];
                  bit_idx   <= 3'h7;
                  link.cs_n <= 1'b0;
                  link.si   <= reg_wdata[7];
                  state     <= hs_shift;
               end
            end
            hs_shift: begin
               if (half_done) begin
                  if (!link.sck) begin
                     link.sck <= 1'b1;
                     rx       <= {rx[6:0], miso_sync[1]};
                  end else begin
                     link.sck <= 1'b0;
                     if (bit_idx == 3'h0) begin
                        state <= hs_finish;
                     end else begin
                        bit_idx <= bit_idx - 3'h1;
                        link.si <= tx[bit_idx - 3'h1];
                     end
                  end
               end
            end
            hs_finish: begin
               // select rises while the clock is still low after the last bit
               if (half_done) begin
                  if (end_frame) begin
                     link.cs_n <= 1'b1;
                  end
                  state <= hs_idle;
               end
            end
            default: state <= hs_idle;
         endcase
      end
   end
endmodule
`default_nettype wire

//--- tb/spi_eeprom_monitor.sv
// assertion checker beside the eeprom link
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_monitor #(
   parameter int WRITE_CYCLES = 20
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // link pins and device status
   input wire logic sck,
   input wire logic cs_n,
   input wire logic si,
   input wire logic so,
   input wire logic so_oe,
   input wire logic busy
);
   logic       sck_d, fbusy;
   logic [8:0] bits;
   logic [7:0] opc;
   logic [2:0] op3;
   int         bcnt;
   // bit 3 is don't care; a bad upper nibble maps to the unused code 7
   assign op3 = (opc[7:4] == 4'h0) ? opc[2:0] : 3'h7;
   // busy is caught while deselected, so it tells how the next frame starts
   always_ff @(posedge sys_clk) begin
      sck_d <= sck;
      bcnt  <= (srst || !busy) ? 0 : bcnt + 1;
      if (srst || cs_n) begin
         bits  <= 9'h000;
         fbusy <= busy;
      end else if (sck && !sck_d) begin
         bits <= bits + 9'h001;
         if (bits < 9'h008)
            opc <= {opc[6:0], si};
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   sequence read_data_seq;
      !cs_n && !fbusy && op3 == 3'h3 && bits >= 9'h019;
   endsequence
   sequence busy_cmd_seq;
      !cs_n && fbusy && busy && bits >= 9'h008;
   endsequence
   a_read_data_out: assert property (read_data_seq |-> so_oe)
      else $error("read data not driven");
   a_addr_quiet: assert property (!cs_n && op3 == 3'h3 && bits >= 9'h009 && bits <= 9'h017 |-> !so_oe)
      else $error("output driven during address");
   a_write_quiet: assert property (!cs_n && op3 == 3'h2 && bits >= 9'h009 |-> !so_oe)
      else $error("output driven during write");
   a_busy_ignores_cmd: assert property (busy_cmd_seq |-> op3 == 3'h5 || !so_oe)
      else $error("command served while busy");
   a_status_busy_ones: assert property (busy_cmd_seq ##0 ($rose(sck) && op3 == 3'h5 && bits <= 9'h00F) |-> so)
      else $error("busy status bit not one");
   a_so_stable_high: assert property (!cs_n && sck && $past(sck) |-> $stable(so))
      else $error("output moved while clock high");
   a_so_idle: assert property (cs_n && $past(cs_n) |-> !so_oe && !so)
      else $error("output active while deselected");
   a_busy_after_frame: assert property ($rose(busy) |-> cs_n)
      else $error("write cycle began inside a frame");
   a_busy_length: assert property ($fell(busy) |-> bcnt >= WRITE_CYCLES - 1 && bcnt <= WRITE_CYCLES + 1)
      else $error("write cycle length wrong");
   a_deselect_on_byte: assert property ($rose(cs_n) |-> !sck && bits[2:0] == 3'h0 && bits != 9'h000)
      else $error("frame ended off a byte boundary");
endmodule
`default_nettype wire

//--- tb/test_spi_eeprom_rw_protect_seq.sv
// self-checking bench: register port frames into the eeprom
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; $display("BAD %s exp %h got %h", n, e, g); end end
module test_spi_eeprom_rw_protect_seq;
   localparam int WCYC = 800;
   logic        sys_clk, srst, reg_wr, reg_rd, busy, pen, wp;
   logic [1:0]  reg_addr, bp;
   logic [15:0] reg_wdata, reg_rdata, a;
   logic [7:0]  r, s;
   logic [7:0]  ref_mem [0:1023];
   bit          known [0:1023];
   logic [15:0] edge_a [4] = '{16'h01FF, 16'h0200, 16'h02FF, 16'h0300};
   int          fails, tests_run, seed, k, j;
   spi_link_if link_bus ();
   eeprom_device #(.ADDR_BITS(10), .WRITE_CYCLES(WCYC)) eeprom_device_inst (
      .sys_clk(sys_clk), .srst(srst), .link(link_bus.device_end), .busy(busy));
   spi_master_ctrl #(.SCK_HALF(4)) spi_master_ctrl_inst (
      .sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link(link_bus.master_end));
   spi_eeprom_monitor #(.WRITE_CYCLES(WCYC)) spi_eeprom_monitor_inst (
      .sys_clk(sys_clk), .srst(srst), .sck(link_bus.sck), .cs_n(link_bus.cs_n), .si(link_bus.si),
      .so(link_bus.so), .so_oe(link_bus.so_oe), .busy(busy));
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   function automatic bit prot(input int x);
      x = x & 32'h3FF;
      return bp == 2'h3 || (bp == 2'h2 && x >= 32'h200) || (bp == 2'h1 && x >= 32'h300);
   endfunction
   // page write target: upper bits held, low five roll over
   function automatic int pidx(input int x, input int i);
      return (x & 32'h3E0) | ((x + i) & 32'h1F);
   endfunction
   task automatic wr(input logic [1:0] ad, input logic [15:0] d);
      @(posedge sys_clk);
      reg_addr  <= ad;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] ad, output logic [15:0] d);
      @(posedge sys_clk);
      reg_addr <= ad;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic xfer(input logic [7:0] b, input logic last, output logic [7:0] q);
      logic [15:0] st;
      int n;
      wr(2'h0, {7'h00, last, b});
      n = 0;
      do begin
         rd(2'h2, st);
         n++;
      end while (st[0] !== 1'b0 && n < 100);
      `CHK("byte done", 1'b0, st[0])
      `CHK("frame open", ~last, st[1])
      rd(2'h1, st);
      q = st[7:0];
      // keep select high long enough for the device to commit
      if (last)
         repeat (8) @(posedge sys_clk);
   endtask
   task automatic op1(input logic [7:0] op);
      xfer(op, 1'b1, r);
   endtask
   task automatic stat(output logic [7:0] v);
      xfer(8'h05, 1'b0, r);
      xfer(8'h00, 1'b1, v);
   endtask
   task automatic hdr(input logic [7:0] op, input logic [15:0] x);
      xfer(op, 1'b0, r);
      xfer(x[15:8], 1'b0, r);
      xfer(x[7:0], 1'b0, r);
   endtask
   // clr: latch state unknown, so it is cleared before the status check
   task automatic ready(input bit clr);
      int n;
      n = 0;
      do begin
         stat(s);
         n++;
      end while (s[0] !== 1'b0 && n < 40);
      if (clr) begin
         op1(8'h04);
         stat(s);
      end
      `CHK("status", {pen, 3'h0, bp, 2'h0}, s)
   endtask
   task automatic mwrite(input logic [15:0] x, input int n, input bit en);
      logic [7:0] d;
      int i;
      if (en)
         op1(8'h06);
      hdr(en ? 8'h0A : 8'h02, x);
      for (i = 0; i < n; i++) begin
         d = 8'($random(seed));
         xfer(d, i == n - 1, r);
         if (en && !prot(pidx(x, i))) begin
            ref_mem[pidx(x, i)] = d;
            known[pidx(x, i)] = 1'b1;
         end
      end
      if (en && !prot(x)) begin
         stat(s);
         `CHK("busy status", 8'hFF, s)
         hdr(8'h03, x);
         xfer(8'h00, 1'b1, r);
         `CHK("read while busy", 8'h00, r)
      end
      ready(!(en && !prot(x)));
   endtask
   task automatic mread(input logic [15:0] x, input int n);
      int i;
      hdr(8'h0B, x);
      for (i = 0; i < n; i++) begin
         // random input traffic during data must not disturb the stream
         xfer(8'($random(seed)), i == n - 1, r);
         if (known[(x + i) & 32'h3FF])
            `CHK("array read", ref_mem[(x + i) & 32'h3FF], r)
      end
   endtask
   task automatic swrite(input logic [7:0] v);
      bit h;
      h = pen && !wp;
      op1(8'h06);
      xfer(8'h01, 1'b0, r);
      xfer(v, 1'b1, r);
      if (!h) begin
         pen = v[7];
         bp = v[3:2];
      end
      ready(h);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #(2_000_000);
      fails++;
      $display("BAD watchdog exp done got timeout");
      complete_run();
   end
   initial begin
      seed = 38364;
      fails = 0;
      tests_run = 0;
      bp = 2'h0;
      pen = 1'b0;
      wp = 1'b1;
      // reset rises on a clock edge so the link-side async reset sees a real edge
      srst = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 2'h0;
      reg_wdata = 16'h0000;
      @(posedge sys_clk);
      srst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      srst <= 1'b0;
      ready(1'b0);
      for (k = 0; k < 3; k++) begin
         a = 16'($random(seed));
         j = 1 + ($random(seed) & 7);
         mwrite(a, j, 1'b1);
         mread(a ^ 16'hFC00, j);
      end
      mwrite(16'h01DE, 34, 1'b1);
      mread(16'h01C0, 32);
      mwrite(16'h03FF, 1, 1'b1);
      mwrite(16'h0000, 1, 1'b1);
      mread(16'h03FF, 2);
      mwrite(16'h01C0, 2, 1'b0);
      mread(16'h01C0, 2);
      for (k = 0; k < 4; k++) begin
         swrite({4'h0, 2'(k), 2'h0});
         for (j = 0; j < 4; j++) begin
            mwrite(edge_a[j], 1, 1'b1);
            mread(edge_a[j], 1);
         end
      end
      swrite(8'h84);
      wr(2'h3, 16'h0000);
      rd(2'h3, a);
      `CHK("pin level", 16'h0000, a)
      wp = 1'b0;
      swrite(8'h00);
      mwrite(16'h0100, 1, 1'b1);
      mwrite(16'h0300, 1, 1'b1);
      mread(16'h0100, 1);
      mread(16'h0300, 1);
      wr(2'h3, 16'h0001);
      wp = 1'b1;
      swrite(8'h00);
      complete_run();
   end
endmodule
`default_nettype wire
